// ---- verilog/isl_slave_top.sv ----
// Two-wire slave port with register pointer, page select and program download window.
`include "isl_map.svh"

// Summary of operation
// RULE_01: Data changes only while clock is low; one bit per clock pulse.
// RULE_02: Bytes are whole, each followed by a ninth acknowledge slot.
// RULE_03: Any number of data bytes between start and stop is accepted.
// RULE_04: Every byte taken in is acknowledged; master clocks the ack slot.
// RULE_05: Ack holds data line low for the whole high phase of its clock.
// RULE_06: On master not-acknowledge the device releases the data line.
// RULE_07: All bytes move most significant bit first.
// RULE_08: A repeated start opens a new transfer like a fresh start.
// RULE_09: First byte is 7-bit address plus direction; 1 means read.
// RULE_10: A matching address byte is acknowledged in the next slot.
// RULE_11: First written byte after address loads the register pointer.
// RULE_12: Further written bytes are acknowledged, stored, pointer then advances.
// RULE_13: Reads start at the pointer, keeping its last stored value.
// RULE_14: Master acks every read byte except the last, which it nacks.
// RULE_15: Page field bits 2:0 resets to zero; codes above five unused.
// RULE_16: Page n covers instruction addresses n*16 to n*16+15.
// RULE_17: Offsets 0x50 to 0x6f hold sixteen words, high byte first.
// RULE_18: Start is data falling with clock high; stop is data rising.
// RULE_19: Address low two bits follow the two strap pins; the code adds the strap pair to base 0x32 instead.
// RULE_20: Pointer advances after each transmitted byte in a read.
// RULE_21: A non-matching address leaves the line released until next start.
module isl_slave_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps.
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  // Engine program read port.
  input wire logic [6:0] prog_rd_addr,
  output logic [15:0] prog_rd_data,
  // Status.
  output logic [2:0] program_page,
  output isl_pkg::isl_state_t link_state
);
  import isl_pkg::*;

  isl_state_t state_ff;
  isl_phase_t phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shreg_ff;
  logic [7:0] ptr_ff;
  logic [2:0] program_page_choice_ff;
  logic rw_ff;
  logic mack_ok_ff;
  logic oe_ff;

  logic [3:0] pins_sync;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic scl_hi;
  logic sda_lvl;

  logic rx_done;
  logic addr_hit;
  logic win_hit;
  logic page_ok;
  logic [7:0] win_ofs;
  logic [7:0] rd_data;
  logic tx_load;
  logic wr_fire;

  isl_mem_if mif ();

  // Pins enter through the synchroniser; straps are followed continuously.
  isl_pin_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pins_raw({scl_in, sda_in, addr_strap_bit1, addr_strap_bit0}),
    .pins_sync(pins_sync),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  isl_prog_mem u_mem (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .m(mif.mem),
    .prog_rd_addr(prog_rd_addr),
    .prog_rd_data(prog_rd_data)
  );

  assign scl_hi = pins_sync[3];
  assign sda_lvl = pins_sync[2];

  // Byte completion, address match and download window decode.
  assign rx_done = (state_ff == ISL_ST_RX) && (bit_cnt_ff == `ISL_RX_LAST) && scl_fall; // [RULE_02]
  assign addr_hit = (shreg_ff[7:1] == 7'(`ISL_ADDR_BASE7 + {`ISL_PAGE_PAD, pins_sync[1], pins_sync[0]})); // [RULE_09] [RULE_19]
  assign win_hit = (ptr_ff >= `ISL_OFS_WIN_LO) && (ptr_ff <= `ISL_OFS_WIN_HI);
  assign page_ok = (program_page_choice_ff <= `ISL_PAGE_MAX); // [RULE_15]
  assign win_ofs = ptr_ff - `ISL_OFS_WIN_LO;
  assign wr_fire = rx_done && (phase_ff == ISL_PH_DATA);
  assign tx_load = scl_fall && (((state_ff == ISL_ST_ACK) && rw_ff) ||
                                ((state_ff == ISL_ST_MACK) && mack_ok_ff));

  // Even window offsets are the high byte of a word, odd ones the low byte.
  assign mif.wr_en = wr_fire && win_hit && page_ok; // [RULE_17]
  assign mif.wr_addr = {program_page_choice_ff, win_ofs[4:1]}; // [RULE_16]
  assign mif.wr_upper = !win_ofs[0];
  assign mif.wr_byte = shreg_ff;
  assign mif.rd_addr = {program_page_choice_ff, win_ofs[4:1]};
  assign mif.rd_upper = !win_ofs[0];

  // Read mux: unmapped offsets and unusable pages read zero.
  always_comb begin
    rd_data = `ISL_BYTE_ZERO;
    if (ptr_ff == `ISL_OFS_PAGE) begin
      rd_data = {`ISL_PAGE_PAD, program_page_choice_ff};
    end else if (win_hit && page_ok) begin
      rd_data = mif.rd_byte;
    end
  end

  // Link state machine; stop and start override whatever byte is in flight.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ISL_ST_IDLE;
    end else if (stop_det) begin
      state_ff <= ISL_ST_IDLE;
    end else if (start_det) begin
      state_ff <= ISL_ST_RX; // [RULE_08]
    end else begin
      unique case (state_ff)
        ISL_ST_IDLE: begin
          state_ff <= ISL_ST_IDLE;
        end
        ISL_ST_RX: begin
          if (rx_done) begin
            if (phase_ff == ISL_PH_ADDR) begin
              state_ff <= addr_hit ? ISL_ST_ACK : ISL_ST_IDLE; // [RULE_10] [RULE_21]
            end else begin
              state_ff <= ISL_ST_ACK; // [RULE_04] [RULE_03]
            end
          end
        end
        ISL_ST_ACK: begin
          if (scl_fall) begin
            state_ff <= rw_ff ? ISL_ST_TX : ISL_ST_RX;
          end
        end
        ISL_ST_TX: begin
          if (scl_fall && (bit_cnt_ff == `ISL_TX_LAST)) begin
            state_ff <= ISL_ST_MACK;
          end
        end
        ISL_ST_MACK: begin
          if (scl_fall) begin
            state_ff <= mack_ok_ff ? ISL_ST_TX : ISL_ST_IDLE; // [RULE_14] [RULE_06]
          end
        end
        default: begin
          state_ff <= ISL_ST_IDLE;
        end
      endcase
    end
  end

  // Direction is fixed by the address byte; phase steps from address to pointer to data.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= ISL_PH_ADDR;
      rw_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      phase_ff <= ISL_PH_ADDR;
      rw_ff <= 1'b0;
    end else if (rx_done) begin
      if (phase_ff == ISL_PH_ADDR) begin
        rw_ff <= shreg_ff[0]; // [RULE_09]
        phase_ff <= ISL_PH_PTR;
      end else begin
        phase_ff <= ISL_PH_DATA;
      end
    end
  end

  // Bit counter: counts rising edges on receive and falling edges on transmit.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_ff <= `ISL_CNT_RST;
    end else if (start_det || tx_load) begin
      bit_cnt_ff <= `ISL_CNT_RST;
    end else if ((state_ff == ISL_ST_ACK) && scl_fall) begin
      bit_cnt_ff <= `ISL_CNT_RST;
    end else if ((state_ff == ISL_ST_RX) && scl_rise) begin
      bit_cnt_ff <= bit_cnt_ff + `ISL_CNT_ONE; // [RULE_01]
    end else if ((state_ff == ISL_ST_TX) && scl_fall) begin
      bit_cnt_ff <= bit_cnt_ff + `ISL_CNT_ONE;
    end
  end

  // Shift register: samples at rising clock, shifts out at falling clock, MSB first.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shreg_ff <= `ISL_BYTE_ZERO;
    end else if (tx_load) begin
      shreg_ff <= rd_data; // [RULE_13]
    end else if ((state_ff == ISL_ST_RX) && scl_rise) begin
      shreg_ff <= {shreg_ff[6:0], sda_lvl}; // [RULE_07]
    end else if ((state_ff == ISL_ST_TX) && scl_fall) begin
      shreg_ff <= {shreg_ff[6:0], 1'b0}; // [RULE_07]
    end
  end

  // Register pointer survives between transfers, so a bare read resumes where it was.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ff <= `ISL_PTR_RST;
    end else if (rx_done && (phase_ff == ISL_PH_PTR)) begin
      ptr_ff <= shreg_ff; // [RULE_11]
    end else if (wr_fire) begin
      ptr_ff <= ptr_ff + `ISL_PTR_ONE; // [RULE_12]
    end else if (tx_load) begin
      ptr_ff <= ptr_ff + `ISL_PTR_ONE; // [RULE_20]
    end
  end

  // Page selection register; unusable codes are stored but block the window.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      program_page_choice_ff <= `ISL_PAGE_RST; // [RULE_15]
    end else if (wr_fire && (ptr_ff == `ISL_OFS_PAGE)) begin
      program_page_choice_ff <= shreg_ff[2:0]; // [RULE_15]
    end
  end

  // Master acknowledge is sampled while the clock is high.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mack_ok_ff <= 1'b0;
    end else if ((state_ff == ISL_ST_MACK) && scl_rise) begin
      mack_ok_ff <= !sda_lvl; // [RULE_14]
    end
  end

  // Data line drive changes one cycle after a falling clock, well inside the low phase, except the release on start or stop.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oe_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      oe_ff <= 1'b0;
    end else if (rx_done) begin
      oe_ff <= (phase_ff == ISL_PH_ADDR) ? addr_hit : 1'b1; // [RULE_05] [RULE_21]
    end else if (tx_load) begin
      oe_ff <= !rd_data[7]; // [RULE_07]
    end else if ((state_ff == ISL_ST_ACK) && scl_fall) begin
      oe_ff <= 1'b0;
    end else if ((state_ff == ISL_ST_TX) && scl_fall) begin
      oe_ff <= (bit_cnt_ff == `ISL_TX_LAST) ? 1'b0 : !shreg_ff[6]; // [RULE_01]
    end else if ((state_ff == ISL_ST_MACK) && scl_fall) begin
      oe_ff <= 1'b0; // [RULE_06]
    end
  end

  // Open drain: the pin only ever pulls low.
  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;
  assign program_page = program_page_choice_ff;
  assign link_state = state_ff;

  // Steps of a received byte and of a read hand-off.
  sequence s_rx_byte_done;
    rx_done;
  endsequence

  sequence s_ack_hold;
    (state_ff == ISL_ST_ACK) && sda_oe;
  endsequence

  sequence s_nack_seen;
    (state_ff == ISL_ST_MACK) && scl_fall && !mack_ok_ff;
  endsequence

  a_oe_stable_high: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_01]
    (scl_hi && $past(scl_hi) && !$past(start_det) && !$past(stop_det)) |-> $stable(sda_oe))
    else $error("Data drive changed while clock high.");

  a_ack_addr_match: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_10]
    (s_rx_byte_done and (phase_ff == ISL_PH_ADDR) && addr_hit && !start_det && !stop_det)
    |=> s_ack_hold)
    else $error("Matching address not acknowledged.");

  a_nomatch_release: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_21]
    (rx_done && (phase_ff == ISL_PH_ADDR) && !addr_hit && !start_det && !stop_det)
    |=> (state_ff == ISL_ST_IDLE) && !sda_oe)
    else $error("Foreign address not ignored.");

  a_ack_low_high: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_05]
    ((state_ff == ISL_ST_ACK) && scl_hi) |-> sda_oe)
    else $error("Ack not held low during clock high.");

  a_ptr_load: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_11]
    (rx_done && (phase_ff == ISL_PH_PTR) && !start_det && !stop_det) |=> (ptr_ff == $past(shreg_ff)))
    else $error("Pointer not loaded from first written byte.");

  a_write_incr: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_12]
    (wr_fire && !start_det && !stop_det) |=> (ptr_ff == 8'($past(ptr_ff) + `ISL_PTR_ONE)) && sda_oe)
    else $error("Write byte not acked or pointer not advanced.");

  a_read_incr: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_20]
    (tx_load && !start_det && !stop_det) |=> (ptr_ff == 8'($past(ptr_ff) + `ISL_PTR_ONE)))
    else $error("Pointer not advanced after transmitted byte.");

  a_tx_msb_first: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_07]
    (tx_load && !start_det && !stop_det) |=> (sda_oe == !$past(rd_data[7])) && (state_ff == ISL_ST_TX))
    else $error("First transmitted bit is not the MSB.");

  a_nack_release: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_06]
    (s_nack_seen and !start_det && !stop_det) |=> (!sda_oe && (state_ff == ISL_ST_IDLE)) [*2])
    else $error("Data line not released after master nack.");

  a_restart_new: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_08]
    (start_det && !stop_det) |=> (state_ff == ISL_ST_RX) && (phase_ff == ISL_PH_ADDR) &&
    (bit_cnt_ff == `ISL_CNT_RST) && !sda_oe)
    else $error("Start did not open a new transfer.");

  a_page_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_15]
    (wr_fire && (ptr_ff == `ISL_OFS_PAGE) && !start_det && !stop_det)
    |=> (program_page == $past(shreg_ff[2:0])))
    else $error("Page selection not updated.");

  a_win_guard: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE_17]
    mif.wr_en |-> (win_hit && (program_page_choice_ff <= `ISL_PAGE_MAX) &&
    (mif.wr_addr == {program_page_choice_ff, win_ofs[4:1]})))
    else $error("Window write outside page or range.");

endmodule : isl_slave_top

// ---- verilog/isl_map.svh ----
// Named constants for the serial program loader port: address, offsets, counts and reset values.
`ifndef ISL_MAP_SVH
`define ISL_MAP_SVH

// Slave address with both straps low; the strap pair is added to it, giving four consecutive addresses.
`define ISL_ADDR_BASE7 7'h32
// Register offsets reached through the pointer.
`define ISL_OFS_PAGE 8'h4f
`define ISL_OFS_WIN_LO 8'h50
`define ISL_OFS_WIN_HI 8'h6f
// Page selection: width, reset value, highest usable code.
`define ISL_PAGE_W 3
`define ISL_PAGE_RST 3'h0
`define ISL_PAGE_MAX 3'h5
`define ISL_PAGE_PAD 5'h00
// Program store geometry: six pages of sixteen 16-bit words.
`define ISL_MEM_DEPTH 96
`define ISL_MEM_LAST 7'h5f
`define ISL_MEM_AW 7
// Bit counts for one byte on the wire.
`define ISL_RX_LAST 4'h8
`define ISL_TX_LAST 4'h7
`define ISL_CNT_RST 4'h0
`define ISL_CNT_ONE 4'h1
`define ISL_PTR_RST 8'h00
`define ISL_PTR_ONE 8'h01
`define ISL_BYTE_ZERO 8'h00
`define ISL_WORD_ZERO 16'h0000
// Number of pin inputs taken through the synchroniser.
`define ISL_SYNC_N 4

`endif

// ---- verilog/isl_pkg.sv ----
// Types shared by the serial program loader port.
package isl_pkg;

  // Byte-level link states, Gray coded along idle, receive, ack, transmit, master ack.
  typedef enum logic [2:0] {
    ISL_ST_IDLE = 3'h0,
    ISL_ST_RX = 3'h1,
    ISL_ST_ACK = 3'h3,
    ISL_ST_TX = 3'h2,
    ISL_ST_MACK = 3'h6
  } isl_state_t;

  // Meaning of the next received byte.
  typedef enum logic [1:0] {
    ISL_PH_ADDR = 2'h0,
    ISL_PH_PTR = 2'h1,
    ISL_PH_DATA = 2'h3
  } isl_phase_t;

endpackage : isl_pkg

// ---- verilog/isl_mem_if.sv ----
// Interface between the link controller and the program store.
interface isl_mem_if;
  logic wr_en;
  logic [6:0] wr_addr;
  logic wr_upper;
  logic [7:0] wr_byte;
  logic [6:0] rd_addr;
  logic rd_upper;
  logic [7:0] rd_byte;

  modport ctl (output wr_en, output wr_addr, output wr_upper, output wr_byte,
               output rd_addr, output rd_upper, input rd_byte);
  modport mem (input wr_en, input wr_addr, input wr_upper, input wr_byte,
               input rd_addr, input rd_upper, output rd_byte);
endinterface : isl_mem_if

// ---- verilog/isl_pin_sync.sv ----
// Pin synchroniser and bus condition detector for the serial port.
`include "isl_map.svh"

module isl_pin_sync (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Raw pins: scl, sda, strap bit 1, strap bit 0.
  input wire logic [3:0] pins_raw,
  // Synchronised levels.
  output logic [3:0] pins_sync,
  // Events, one cycle each.
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;

  // Two flip-flops per pin; only the second stage is read by logic.
  genvar gi;
  generate
    for (gi = 0; gi < `ISL_SYNC_N; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pins_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  // Previous synchronised levels give the edges.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= sync_ff[3];
      sda_prev_ff <= sync_ff[2];
    end
  end

  // Both lines share one delay, so their relative order survives the crossing.
  assign pins_sync = sync_ff;
  assign scl_rise = sync_ff[3] && !scl_prev_ff;
  assign scl_fall = !sync_ff[3] && scl_prev_ff;
  assign start_det = sync_ff[3] && scl_prev_ff && sda_prev_ff && !sync_ff[2]; // [RULE_18]
  assign stop_det = sync_ff[3] && scl_prev_ff && !sda_prev_ff && sync_ff[2]; // [RULE_18]

endmodule : isl_pin_sync

// ---- verilog/isl_prog_mem.sv ----
// Program store: six pages of sixteen instruction words, byte-written from the link.
`include "isl_map.svh"

module isl_prog_mem (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link side.
  isl_mem_if.mem m,
  // Engine read port.
  input wire logic [6:0] prog_rd_addr,
  output logic [15:0] prog_rd_data
);

  logic [15:0] words [0:`ISL_MEM_DEPTH-1];

  // Byte write into the upper or lower half of one word.
  always_ff @(posedge clk_sys) begin
    if (m.wr_en) begin
      if (m.wr_upper) begin
        words[m.wr_addr][15:8] <= m.wr_byte;
      end else begin
        words[m.wr_addr][7:0] <= m.wr_byte;
      end
    end
  end

  // Link read is combinational so the byte is ready at the load edge.
  always_comb begin
    m.rd_byte = `ISL_BYTE_ZERO;
    if (m.rd_addr <= `ISL_MEM_LAST) begin
      m.rd_byte = m.rd_upper ? words[m.rd_addr][15:8] : words[m.rd_addr][7:0];
    end
  end

  // Engine read is registered; addresses past the store read zero.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prog_rd_data <= `ISL_WORD_ZERO;
    end else if (prog_rd_addr <= `ISL_MEM_LAST) begin
      prog_rd_data <= words[prog_rd_addr];
    end else begin
      prog_rd_data <= `ISL_WORD_ZERO;
    end
  end

endmodule : isl_prog_mem

// ---- tb/isl_master_model.sv ----
// Bus master model that clocks the slave port the way a host controller does.
module isl_master_model (
  // System clock that paces every bus change.
  input wire logic clk_sys,
  // Resolved data wire.
  input wire logic sda_wire,
  // Bus clock and data pull-down.
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  logic odd;
  int n_unstable;

  // Bus idle at time zero: both lines released high.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    odd = 1'b0;
    n_unstable = 0;
  end

  // All changes land on falling system clock edges, away from the sampling edge.
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_n

  // One bit slot; the low phase alternates 6 and 7 cycles for a 125 ns average period.
  task automatic bit_slot(input logic b, output logic s);
    logic s_early;
    wait_n(3);
    sda_pull = !b;
    wait_n(3 + int'(odd));
    odd = !odd;
    scl = 1'b1;
    wait_n(2);
    s_early = sda_wire;
    wait_n(4);
    s = sda_wire;
    if (s_early !== s) n_unstable++;
    scl = 1'b0;
  endtask : bit_slot

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    wait_n(3);
    sda_pull = 1'b0;
    wait_n(3);
    scl = 1'b1;
    wait_n(6);
    sda_pull = 1'b1;
    wait_n(6);
    scl = 1'b0;
  endtask : start_cond

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop_cond();
    wait_n(3);
    sda_pull = 1'b1;
    wait_n(3);
    scl = 1'b1;
    wait_n(6);
    sda_pull = 1'b0;
    wait_n(6);
  endtask : stop_cond

  // Sends a byte and clocks the ninth slot, where the slave answers.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask : send_byte

  // Clocks a byte out of the slave, then acknowledges or, on the last byte, withholds it.
  task automatic recv_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
    bit_slot(!mack, s);
  endtask : recv_byte
endmodule : isl_master_model

// ---- tb/i2c_slave_program_loader_test.sv ----
// Self-checking bench for the serial program loader port.
module i2c_slave_program_loader_test;
  timeunit 1ns;
  timeprecision 1ps;
  import isl_pkg::*;

  typedef struct packed {logic [2:0] page; logic [3:0] slot; logic [15:0] word;} isl_row_t;
  localparam isl_row_t ROWS [6] = '{'{3'h0, 4'h0, 16'h1234}, '{3'h1, 4'hf, 16'habcd}, '{3'h2, 4'h7, 16'h00ff},
    '{3'h3, 4'h1, 16'hff00}, '{3'h4, 4'he, 16'h5aa5}, '{3'h5, 4'h8, 16'h0001}};

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [6:0] prog_rd_addr = 7'h00;
  logic scl, sda_pull, sda_out, sda_oe, sda_wire, ack;
  logic [15:0] prog_rd_data;
  logic [2:0] program_page;
  isl_state_t link_state;
  logic [6:0] dev;
  logic [7:0] tx [33];
  logic [7:0] rx [4];
  int n_mismatch = 0;
  int comparisons = 0;

  // Open-drain wire with a pull-up; the strap pair picks one of four addresses.
  assign sda_wire = !(sda_pull || (sda_oe && !sda_out));
  assign dev = 7'h32 + {5'h00, strap};

  // Free-running system clock.
  always #5 clk_sys = !clk_sys;

  isl_slave_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .prog_rd_addr(prog_rd_addr),
    .prog_rd_data(prog_rd_data), .program_page(program_page), .link_state(link_state));
  isl_master_model i_mst (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

  // Case-equality compare so an unknown never passes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Write transfer without a stop, so the caller picks stop or repeated start.
  task automatic wr(input logic [7:0] ptr, input int n);
    i_mst.start_cond();
    i_mst.send_byte({dev, 1'b0}, ack);
    check(ack, 1'b1);
    i_mst.send_byte(ptr, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_mst.send_byte(tx[i], ack);
      check(ack, 1'b1);
    end
  endtask : wr

  // Read transfer; the released line and idle state are checked before the stop.
  task automatic rd(input int n);
    i_mst.start_cond();
    i_mst.send_byte({dev, 1'b1}, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) i_mst.recv_byte(i < n - 1, rx[i]);
    repeat (6) @(negedge clk_sys);
    check(sda_oe, 1'b0);
    check(link_state, ISL_ST_IDLE);
    i_mst.stop_cond();
  endtask : rd

  // The bus should be done well inside this span; a hang ends the run as a failure.
  initial begin
    #1ms;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(program_page, 3'h0);
    check(link_state, ISL_ST_IDLE);
    check(sda_oe, 1'b0);
    // Table rows: set the page, then write and read back one word through both ports.
    foreach (ROWS[k]) begin
      tx[0] = {5'h00, ROWS[k].page};
      wr(8'h4f, 1);
      tx[0] = ROWS[k].word[15:8];
      tx[1] = ROWS[k].word[7:0];
      wr(8'h50 + {3'h0, ROWS[k].slot, 1'b0}, 2);
      i_mst.stop_cond();
      check(program_page, ROWS[k].page);
      prog_rd_addr = {ROWS[k].page, ROWS[k].slot};
      repeat (2) @(negedge clk_sys);
      check(prog_rd_data, ROWS[k].word);
      wr(8'h50 + {3'h0, ROWS[k].slot, 1'b0}, 0);
      rd(2);
      check({rx[0], rx[1]}, ROWS[k].word);
    end
    // A whole page in one burst: page select byte, then all 32 window bytes.
    tx[0] = 8'h02;
    for (int i = 1; i < 33; i++) tx[i] = 8'h10 + 8'(i);
    wr(8'h4f, 33);
    i_mst.stop_cond();
    for (int w = 0; w < 16; w++) begin
      prog_rd_addr = {3'h2, 4'(w)};
      repeat (2) @(negedge clk_sys);
      check(prog_rd_data, {tx[2 * w + 1], tx[2 * w + 2]});
    end
    // Block read advances the pointer; a later read without a pointer write continues from it.
    wr(8'h4f, 0);
    rd(3);
    check({rx[0], rx[1], rx[2]}, {8'h02, tx[1], tx[2]});
    rd(1);
    check(rx[0], tx[3]);
    // Unusable page code is stored but the window neither stores nor returns data.
    tx[0] = 8'h06;
    tx[1] = 8'h99;
    wr(8'h4f, 2);
    i_mst.stop_cond();
    check(program_page, 3'h6);
    prog_rd_addr = 7'h20;
    repeat (2) @(negedge clk_sys);
    check(prog_rd_data, {8'h11, 8'h12});
    wr(8'h50, 0);
    rd(1);
    check(rx[0], 8'h00);
    // Every strap setting: own address answers, a neighbour's address is ignored.
    for (int s = 0; s < 4; s++) begin
      strap = 2'(s);
      repeat (4) @(negedge clk_sys);
      tx[0] = 8'h01;
      wr(8'h4f, 1);
      i_mst.stop_cond();
      i_mst.start_cond();
      i_mst.send_byte({dev ^ 7'h01, 1'b0}, ack);
      check(ack, 1'b0);
      i_mst.send_byte(8'h4f, ack);
      check(ack, 1'b0);
      i_mst.stop_cond();
    end
    check(i_mst.n_unstable, 32'h0);
    end_sim();
  end
endmodule : i2c_slave_program_loader_test
